// ---- bench/tb.sv ----
// Purpose: Self-checking bench for the supply fault configuration block
// Assumes: Short ride-through and restart parameters; ce_i held high
// Notes: Inputs change 1 ns after each rising edge; pins need 3 edges to act
`timescale 1ns/100ps
module tb;
  localparam int SLOW = 20;
  localparam int FAST = 8;
  localparam logic [7:0] CFG_A = supply_fault_pkg::FAULT_CONFIG_A_OFS;
  localparam logic [7:0] CFG_B = supply_fault_pkg::FAULT_CONFIG_B_OFS;
  logic clk_i, reset_i, ce_i, reg_wr_i, reg_rd_i, nv_load_i, trim_lock_i;
  logic pen_hi, brk_hi, brk_clr, oc, uv, gnd_ok, ac1, ac2, req;
  logic [7:0] reg_addr_i, reg_wdata_i, nv_a, nv_b, rdata;
  logic pen_o, brk_o, acg_o, ocs_o, clamp_o, on_o;
  int miscompares, check_count;

  // ****************************************
  // Device under test
  // ****************************************
  supply_fault_config_regs #(.RIDE_SLOW_CYC(SLOW), .RIDE_FAST_CYC(FAST),
    .RESTART_PERIOD_CYC(30)) u_dut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .nv_load_i(nv_load_i), .nv_config_a_i(nv_a),
    .nv_config_b_i(nv_b), .trim_lock_i(trim_lock_i), .power_enable_polarity_hi_i(pen_hi),
    .breaker_polarity_hi_i(brk_hi), .breaker_clear_i(brk_clr), .oc_pin_i(oc),
    .uv_pin_i(uv), .gnd_ok_pin_i(gnd_ok), .ac_sense1_pin_i(ac1), .ac_sense2_pin_i(ac2),
    .power_on_req_pin_i(req), .reg_rdata_o(rdata), .power_enable_out_o(pen_o),
    .breaker_out_o(brk_o), .ac_good_out_o(acg_o), .oc_status_o(ocs_o),
    .share_clamp_threshold_o(clamp_o), .supply_on_o(on_o));

  // Free-running 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic chk1(input string name, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %b seen %b", name, e, g);
    end
  endtask

  task automatic chk8(input string name, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    cyc(1);
    reg_wr_i = 1'b0;
    cyc(1);
  endtask

  // Read data is registered, so look one edge after the taking edge
  task automatic rd8(input logic [7:0] a, input logic [7:0] e, input string name);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    cyc(1);
    reg_rd_i = 1'b0;
    cyc(1);
    chk8(name, e, rdata);
  endtask

  // Latched-off supply only recovers after the request drops
  task automatic cycle_req();
    req = 1'b0;
    cyc(5);
    req = 1'b1;
    cyc(5);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    rd8(CFG_A, 8'h00, "cfg_a_reset");
    rd8(CFG_B, 8'h00, "cfg_b_reset");
    wr(CFG_A, 8'hff);
    rd8(CFG_A, 8'he7, "cfg_a_reserved");
    wr(CFG_B, 8'hff);
    rd8(CFG_B, 8'hd9, "cfg_b_write_only");
    wr(8'h13, 8'h55);
    rd8(8'h13, 8'h00, "unmapped");
    trim_lock_i = 1'b1;
    wr(CFG_A, 8'h00);
    rd8(CFG_A, 8'he7, "locked_write");
    nv_a = 8'h41;
    nv_b = 8'h09;
    nv_load_i = 1'b1;
    cyc(1);
    nv_load_i = 1'b0;
    rd8(CFG_A, 8'h41, "nv_load_a");
    rd8(CFG_B, 8'h09, "nv_load_b");
    trim_lock_i = 1'b0;
    wr(CFG_A, 8'h00);
    wr(CFG_B, 8'h00);
    cyc(5);
  endtask

  task automatic t_power();
    req = 1'b1;
    cyc(5);
    chk1("supply_on", 1'b1, on_o);
    chk1("pen_on", 1'b1, pen_o);
    uv = 1'b1;
    cyc(5);
    chk1("uv_off", 1'b0, on_o);
    chk1("brk_trip", 1'b1, brk_o);
    uv = 1'b0;
    cyc(10);
    chk1("stays_off", 1'b0, on_o);
    chk1("brk_follow", 1'b0, brk_o);
    cycle_req();
    chk1("recovered", 1'b1, on_o);
  endtask

  task automatic t_polarity();
    wr(CFG_A, 8'h60);
    cyc(4);
    chk1("pen_inv", 1'b0, pen_o);
    chk1("brk_inv", 1'b1, brk_o);
    pen_hi = 1'b1;
    brk_hi = 1'b1;
    cyc(4);
    chk1("pen_both", 1'b1, pen_o);
    chk1("brk_both", 1'b0, brk_o);
    pen_hi = 1'b0;
    brk_hi = 1'b0;
    wr(CFG_A, 8'h00);
    cyc(4);
  endtask

  // Every period code, slow and fast; just short of the limit, then past it
  task automatic t_ride();
    int lim;
    for (int f = 0; f < 2; f++) begin
      for (int c = 0; c < 4; c++) begin
        wr(CFG_B, 8'(c << 3));
        wr(CFG_A, 8'(f << 2));
        lim = (c + 1) * ((f == 1) ? FAST : SLOW);
        oc = 1'b1;
        cyc(lim - 3);
        chk1("oc_early", 1'b0, ocs_o);
        cyc(8);
        chk1("oc_late", 1'b1, ocs_o);
        chk1("oc_off", 1'b0, on_o);
        oc = 1'b0;
        cyc(4);
        cycle_req();
      end
    end
    wr(CFG_B, 8'h00);
    wr(CFG_A, 8'h00);
  endtask

  task automatic t_mask();
    wr(CFG_A, 8'h80);
    oc = 1'b1;
    cyc(SLOW + 8);
    chk1("mask_flag", 1'b1, ocs_o);
    chk1("mask_on", 1'b1, on_o);
    oc = 1'b0;
    cyc(4);
    wr(CFG_A, 8'h00);
  endtask

  task automatic t_ground();
    gnd_ok = 1'b0;
    cyc(6);
    chk1("gnd_fault", 1'b0, on_o);
    gnd_ok = 1'b1;
    cycle_req();
    wr(CFG_A, 8'h02);
    gnd_ok = 1'b0;
    cyc(6);
    chk1("gnd_ignored", 1'b1, on_o);
    gnd_ok = 1'b1;
    cyc(4);
    wr(CFG_A, 8'h00);
  endtask

  task automatic t_latch();
    wr(CFG_A, 8'h01);
    uv = 1'b1;
    cyc(3);
    uv = 1'b0;
    cyc(8);
    chk1("brk_latched", 1'b1, brk_o);
    brk_clr = 1'b1;
    cyc(1);
    brk_clr = 1'b0;
    cyc(4);
    chk1("brk_cleared", 1'b0, brk_o);
    wr(CFG_A, 8'h00);
    cycle_req();
  endtask

  task automatic t_restart();
    int k;
    wr(CFG_B, 8'h80);
    uv = 1'b1;
    cyc(3);
    uv = 1'b0;
    cyc(5);
    chk1("retry_wait", 1'b0, on_o);
    k = 0;
    while (on_o !== 1'b1 && k < 60) begin
      cyc(1);
      k++;
    end
    chk1("retry_on", 1'b1, on_o);
    wr(CFG_B, 8'h00);
  endtask

  task automatic t_acgood();
    ac1 = 1'b1;
    cyc(5);
    chk1("ac_first", 1'b1, acg_o);
    wr(CFG_B, 8'h04);
    cyc(4);
    chk1("ac_second", 1'b0, acg_o);
    ac1 = 1'b0;
    wr(CFG_B, 8'h62);
    cyc(4);
    chk1("ac_direct1", 1'b1, acg_o);
    wr(CFG_B, 8'h42);
    cyc(4);
    chk1("ac_direct0", 1'b0, acg_o);
    wr(CFG_B, 8'h01);
    cyc(4);
    chk1("clamp_88", 1'b1, clamp_o);
    wr(CFG_B, 8'h00);
    cyc(4);
    chk1("clamp_75", 1'b0, clamp_o);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    {reg_wr_i, reg_rd_i, nv_load_i, trim_lock_i, pen_hi, brk_hi, brk_clr} = '0;
    {oc, uv, ac1, ac2, req} = '0;
    {reg_addr_i, reg_wdata_i, nv_a, nv_b} = '0;
    gnd_ok = 1'b1;
    ce_i = 1'b1;
    miscompares = 0;
    check_count = 0;
    reset_i = 1'b1;
    repeat (12) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    t_regs();
    t_power();
    t_polarity();
    t_ride();
    t_mask();
    t_ground();
    t_latch();
    t_restart();
    t_acgood();
    report_and_stop();
  end
endmodule

// ---- logic/ridethrough_timer.sv ----
// Purpose: Counts cycles while a condition holds and flags when a limit is reached
// Assumes: run_i from same clock domain
// Notes: Count restarts whenever run_i drops
`timescale 1ns/100ps
module ridethrough_timer (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic [supply_fault_pkg::CNT_W-1:0] limit_i,
  output logic expired_o
);

  logic [supply_fault_pkg::CNT_W-1:0] count_q;
  logic [supply_fault_pkg::CNT_W-1:0] count_d;
  logic at_limit;

  // Saturate at the limit so a held condition keeps expired high
  assign at_limit = (count_q >= limit_i);
  assign count_d = !run_i ? '0 : (at_limit ? count_q : count_q + 1'b1);

  // Counter
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_q <= '0;
      expired_o <= 1'b0;
    end else if (ce_i) begin
      count_q <= count_d;
      expired_o <= run_i && at_limit;
    end
  end

endmodule

// ---- logic/supply_fault_config_regs.sv ----
// Purpose: Fault configuration registers and the fault reactions they steer
// Assumes: Byte register port on clk_i; pins asynchronous; NV defaults loaded by pulse
// Notes: Outputs all registered; long periods shortenable by parameter
`timescale 1ns/100ps
module supply_fault_config_regs #(
  parameter int RIDE_SLOW_CYC = supply_fault_pkg::RIDE_SLOW_UNIT_CYC,
  parameter int RIDE_FAST_CYC = supply_fault_pkg::RIDE_FAST_UNIT_CYC,
  parameter int RESTART_PERIOD_CYC = supply_fault_pkg::RESTART_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic nv_load_i,
  input wire logic [7:0] nv_config_a_i,
  input wire logic [7:0] nv_config_b_i,
  input wire logic trim_lock_i,
  input wire logic power_enable_polarity_hi_i,
  input wire logic breaker_polarity_hi_i,
  input wire logic breaker_clear_i,
  input wire logic oc_pin_i,
  input wire logic uv_pin_i,
  input wire logic gnd_ok_pin_i,
  input wire logic ac_sense1_pin_i,
  input wire logic ac_sense2_pin_i,
  input wire logic power_on_req_pin_i,
  output logic [7:0] reg_rdata_o,
  output logic power_enable_out_o,
  output logic breaker_out_o,
  output logic ac_good_out_o,
  output logic oc_status_o,
  output logic share_clamp_threshold_o,
  output logic supply_on_o
);

  // ****************************************
  // Helpers
  // ****************************************
  // Ride-through limit in cycles, (code + 1) units, minus one for the compare
  function automatic logic [supply_fault_pkg::CNT_W-1:0] ride_limit(
    input logic [1:0] code, input logic fast);
    logic [supply_fault_pkg::CNT_W-1:0] unit;
    unit = fast ? supply_fault_pkg::CNT_W'(RIDE_FAST_CYC)
                : supply_fault_pkg::CNT_W'(RIDE_SLOW_CYC);
    ride_limit = supply_fault_pkg::CNT_W'(unit * ({27'h0, code} + 29'h1) - 29'h1);
  endfunction

  // Output polarity: the pair of polarity bits inverts when they differ
  function automatic logic apply_pol(input logic level, input logic lo, input logic hi);
    apply_pol = level ^ lo ^ hi;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  supply_fault_pkg::pins_s pins_raw;
  supply_fault_pkg::pins_s sync1_q;
  supply_fault_pkg::pins_s pins_q;

  assign pins_raw = '{oc: oc_pin_i, uv: uv_pin_i, gnd_ok: gnd_ok_pin_i,
                      ac1: ac_sense1_pin_i, ac2: ac_sense2_pin_i,
                      pson: power_on_req_pin_i};

  // Two stages; first stage feeds only the second
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_q <= '0;
      pins_q <= '0;
    end else if (ce_i) begin
      sync1_q <= pins_raw;
      pins_q <= sync1_q;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  supply_fault_pkg::fault_config_a_s cfg_a_q;
  supply_fault_pkg::fault_config_b_s cfg_b_q;
  logic wr_ok;
  logic wr_a;
  logic wr_b;
  logic [7:0] rd_mux;

  // Lock gates every bus write; NV load still lands
  assign wr_ok = reg_wr_i && !trim_lock_i;
  assign wr_a = wr_ok && (reg_addr_i == supply_fault_pkg::FAULT_CONFIG_A_OFS);
  assign wr_b = wr_ok && (reg_addr_i == supply_fault_pkg::FAULT_CONFIG_B_OFS);
  assign rd_mux = (reg_addr_i == supply_fault_pkg::FAULT_CONFIG_A_OFS) ? cfg_a_q :
                  (reg_addr_i == supply_fault_pkg::FAULT_CONFIG_B_OFS) ?
                  (cfg_b_q & supply_fault_pkg::CONFIG_B_RMASK) :
                  supply_fault_pkg::RESET_BYTE;

  // Config storage; reserved bits never stored
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_a_q <= supply_fault_pkg::RESET_BYTE;
      cfg_b_q <= supply_fault_pkg::RESET_BYTE;
    end else if (ce_i) begin
      if (nv_load_i) begin
        cfg_a_q <= nv_config_a_i & supply_fault_pkg::CONFIG_A_WMASK;
        cfg_b_q <= nv_config_b_i;
      end else begin
        if (wr_a) cfg_a_q <= reg_wdata_i & supply_fault_pkg::CONFIG_A_WMASK;
        if (wr_b) cfg_b_q <= reg_wdata_i;
      end
    end
  end

  // Read data holds until the next read strobe
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= supply_fault_pkg::RESET_BYTE;
    end else if (ce_i && reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end
  end

  // ****************************************
  // Overcurrent ride-through
  // ****************************************
  logic [supply_fault_pkg::CNT_W-1:0] ride_lim;
  logic oc_expired;

  assign ride_lim = ride_limit(cfg_b_q.ridethrough_period, cfg_a_q.fast_ride);

  ridethrough_timer u_ride (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .run_i(pins_q.oc),
    .limit_i(ride_lim),
    .expired_o(oc_expired)
  );

  // ****************************************
  // Power management
  // ****************************************
  logic oc_trip;
  logic gnd_fault;
  logic trip_now;
  logic pson_req;
  logic fault_q;
  logic fault_d;
  logic on_q;
  logic on_d;
  logic [supply_fault_pkg::CNT_W-1:0] retry_q;
  logic [supply_fault_pkg::CNT_W-1:0] retry_d;
  logic retry_done;
  logic brk_act_q;
  logic brk_act_d;

  // Mask keeps overcurrent out of shutdown and breaker decisions only
  assign oc_trip = oc_expired && !cfg_a_q.oc_mask;
  assign gnd_fault = !pins_q.gnd_ok && !cfg_a_q.gnd_dis;
  assign trip_now = on_q && (oc_trip || pins_q.uv || gnd_fault);
  // Microprocessor mode replaces the power-on pin with its own bit
  assign pson_req = cfg_b_q.ac_good_micro_mode ? cfg_b_q.power_on_direct : pins_q.pson;
  assign retry_done = (retry_q == supply_fault_pkg::CNT_W'(RESTART_PERIOD_CYC - 1));
  // Restart mode retries on a timer; otherwise only dropping the request clears
  assign fault_d = trip_now ? 1'b1 :
                   !pson_req ? 1'b0 :
                   (cfg_b_q.restart_mode && retry_done) ? 1'b0 : fault_q;
  assign retry_d = (fault_q && cfg_b_q.restart_mode && !retry_done) ?
                   retry_q + 1'b1 : '0;
  assign on_d = pson_req && !fault_d;
  // Latching breaker: set wins over clear
  assign brk_act_d = cfg_a_q.brk_latch ? (trip_now || (brk_act_q && !breaker_clear_i)) :
                     (trip_now || (fault_q && (oc_trip || pins_q.uv || gnd_fault)));

  // Fault and supply state
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fault_q <= 1'b0;
      on_q <= 1'b0;
      retry_q <= '0;
      brk_act_q <= 1'b0;
    end else if (ce_i) begin
      fault_q <= fault_d;
      on_q <= on_d;
      retry_q <= retry_d;
      brk_act_q <= brk_act_d;
    end
  end

  // ****************************************
  // Output pins
  // ****************************************
  logic ac_src;
  logic ac_good_d;

  assign ac_src = cfg_b_q.ac_sense_sel ? pins_q.ac2 : pins_q.ac1;
  assign ac_good_d = cfg_b_q.ac_good_micro_mode ? cfg_b_q.ac_good_direct : ac_src;

  // Registered outputs, built from the same next values as the state
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      power_enable_out_o <= 1'b0;
      breaker_out_o <= 1'b0;
      ac_good_out_o <= 1'b0;
      oc_status_o <= 1'b0;
      share_clamp_threshold_o <= 1'b0;
      supply_on_o <= 1'b0;
    end else if (ce_i) begin
      power_enable_out_o <= apply_pol(on_d, cfg_a_q.pen_pol_lo,
                                      power_enable_polarity_hi_i);
      breaker_out_o <= apply_pol(brk_act_d, cfg_a_q.brk_pol_lo, breaker_polarity_hi_i);
      ac_good_out_o <= ac_good_d;
      oc_status_o <= oc_expired;
      share_clamp_threshold_o <= cfg_b_q.share_clamp_threshold;
      supply_on_o <= on_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_oc_flag_unmasked: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && oc_expired) |=> oc_status_o)
    else $error("overcurrent flag missing");

  a_oc_mask_holds: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && on_q && cfg_a_q.oc_mask && !pins_q.uv && !gnd_fault && pson_req) |=> on_q)
    else $error("masked overcurrent shut supply");

  // Polarity bits are taken as they stood at the edge that launched the output
  a_pen_polarity: assert property (@(posedge clk_i) disable iff (reset_i)
    ce_i |=> (power_enable_out_o == (supply_on_o ^ $past(cfg_a_q.pen_pol_lo) ^
                                     $past(power_enable_polarity_hi_i))))
    else $error("power enable polarity wrong");

  a_brk_polarity: assert property (@(posedge clk_i) disable iff (reset_i)
    ce_i |=> (breaker_out_o == (brk_act_q ^ $past(cfg_a_q.brk_pol_lo) ^
                                $past(breaker_polarity_hi_i))))
    else $error("breaker polarity wrong");

  a_ride_fast_limit: assert property (@(posedge clk_i) disable iff (reset_i)
    (cfg_a_q.fast_ride && cfg_b_q.ridethrough_period == 2'b11) |->
    (ride_lim == supply_fault_pkg::CNT_W'(4 * RIDE_FAST_CYC - 1)))
    else $error("fast ride-through limit wrong");

  a_gnd_ignored: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && on_q && cfg_a_q.gnd_dis && !pins_q.uv && !oc_trip && pson_req) |=> on_q)
    else $error("disabled ground check tripped");

  a_brk_latch_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && cfg_a_q.brk_latch && brk_act_q && !breaker_clear_i) |=> brk_act_q)
    else $error("latched breaker dropped");

  a_restart_retry: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && fault_q && retry_done && cfg_b_q.restart_mode && pson_req && !trip_now)
    |=> !fault_q)
    else $error("restart did not retry");

  a_latch_off: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && fault_q && !cfg_b_q.restart_mode && pson_req) |=> fault_q)
    else $error("latched fault cleared itself");

  a_ac_select: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && !cfg_b_q.ac_good_micro_mode && cfg_b_q.ac_sense_sel) |=>
    (ac_good_out_o == $past(pins_q.ac2)))
    else $error("ac sense source wrong");

  a_lock_refuse: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && trim_lock_i && !nv_load_i) |=> $stable(cfg_a_q) && $stable(cfg_b_q))
    else $error("write passed trim lock");

  a_oc_trip_off: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && on_q && oc_expired && !cfg_a_q.oc_mask) |=> !on_q)
    else $error("unmasked overcurrent kept supply on");

  a_ride_slow_limit: assert property (@(posedge clk_i) disable iff (reset_i)
    !cfg_a_q.fast_ride |->
    (ride_lim == supply_fault_pkg::CNT_W'((int'(cfg_b_q.ridethrough_period) + 1) *
                                          RIDE_SLOW_CYC - 1)))
    else $error("slow ride-through limit wrong");

  a_brk_follow: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && !cfg_a_q.brk_latch && !(oc_trip || pins_q.uv || gnd_fault)) |=>
    !brk_act_q)
    else $error("non-latching breaker held");

  a_brk_clear: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && cfg_a_q.brk_latch && breaker_clear_i && !trip_now) |=> !brk_act_q)
    else $error("latched breaker not cleared");

  a_ac_first: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && !cfg_b_q.ac_good_micro_mode && !cfg_b_q.ac_sense_sel) |=>
    (ac_good_out_o == $past(pins_q.ac1)))
    else $error("first ac sense source wrong");

  // Micro mode must cut the pins off completely, not just mix in the bit
  a_ac_micro: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && cfg_b_q.ac_good_micro_mode) |=>
    (ac_good_out_o == $past(cfg_b_q.ac_good_direct)))
    else $error("direct ac good ignored");

  a_clamp_follow: assert property (@(posedge clk_i) disable iff (reset_i)
    ce_i |=> (share_clamp_threshold_o == $past(cfg_b_q.share_clamp_threshold)))
    else $error("share clamp threshold wrong");

  a_reserved_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    (cfg_a_q.reserved == 2'h0))
    else $error("reserved bits stored");

endmodule

// ---- logic/supply_fault_pkg.sv ----
// Purpose: Shared constants and carriers for the supply fault configuration block
// Assumes: 100 MHz clk_i; byte-wide register port
// Notes: Long periods are top-level parameters derived from these figures
// Functional notes
// - Overcurrent-mask bit 7 stops overcurrent from reaching power management but the flag still sets.
// - Bit 6 with a companion bit sets the power-enable output polarity.
// - Bit 5 with a companion bit sets the breaker output polarity.
// - Fast ride-through bit 2 swaps the seconds periods for short microsecond periods.
// - Ground-check disable bit 1 removes the ground-continuity input from fault logic.
// - Breaker latch-mode bit makes the breaker output follow the fault or latch until cleared.
// - With restart mode set, the supply retries about once per second after a shutdown.
// - With restart mode clear, faults latch the supply off until the power-on request is cycled.
// - A write-only bit drives ac-good directly in microprocessor mode.
// - The 2-bit ride-through field picks 1 to 4 seconds or 128 to 512 microseconds.
// - The write-only ac-sense select bit picks the first or second ac-sense input.
// - The share-clamp bit sets the release threshold to 75 or 88 percent.
// - While trim-lock is set, register writes are refused.
package supply_fault_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] FAULT_CONFIG_A_OFS = 8'h11;
  localparam logic [7:0] FAULT_CONFIG_B_OFS = 8'h12;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Write mask of first register: reserved bits 4:3 dropped
  localparam logic [7:0] CONFIG_A_WMASK = 8'he7;
  // Read mask of second register: write-only bits 5, 2, 1 read zero
  localparam logic [7:0] CONFIG_B_RMASK = 8'hd9;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int RIDE_SLOW_UNIT_MS = 1000;
  localparam int RIDE_FAST_UNIT_US = 128;
  localparam int RESTART_MS = 1000;
  localparam int RIDE_SLOW_UNIT_CYC = RIDE_SLOW_UNIT_MS * 1000 * CLK_MHZ;
  localparam int RIDE_FAST_UNIT_CYC = RIDE_FAST_UNIT_US * CLK_MHZ;
  localparam int RESTART_CYC = RESTART_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 29;
  localparam int SYNC_W = 6;

  // ****************************************
  // Register layouts
  // ****************************************
  typedef struct packed {
    logic oc_mask;
    logic pen_pol_lo;
    logic brk_pol_lo;
    logic [1:0] reserved;
    logic fast_ride;
    logic gnd_dis;
    logic brk_latch;
  } fault_config_a_s;

  typedef struct packed {
    logic restart_mode;
    logic ac_good_micro_mode;
    logic ac_good_direct;
    logic [1:0] ridethrough_period;
    logic ac_sense_sel;
    logic power_on_direct;
    logic share_clamp_threshold;
  } fault_config_b_s;

  // Synchronised pin bundle
  typedef struct packed {
    logic oc;
    logic uv;
    logic gnd_ok;
    logic ac1;
    logic ac2;
    logic pson;
  } pins_s;

endpackage
